// ===== clock_gating_pkg.sv
// Constants, register map and types for the peripheral clock gating banks.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package clock_gating_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_RUN_GATING_GROUP0 = 12'h100;
  localparam logic [11:0] OFF_RUN_GATING_GROUP1 = 12'h104;
  localparam logic [11:0] OFF_SLEEP_GATING_GROUP0 = 12'h110;
  localparam logic [11:0] OFF_SLEEP_GATING_GROUP1 = 12'h114;
  localparam logic [11:0] OFF_DEEPSLEEP_GATING_GROUP0 = 12'h120;
  localparam logic [11:0] OFF_DEEPSLEEP_GATING_GROUP1 = 12'h124;
  localparam logic [11:0] OFF_MAIN_CLOCK_CONFIGURATION = 12'h130;
  localparam logic [11:0] OFF_EFFECTIVE_GROUP0 = 12'h134;
  localparam logic [11:0] OFF_EFFECTIVE_GROUP1 = 12'h138;
  localparam logic [11:0] OFF_GATING_STATUS = 12'h13c;

  // Register selector codes
  localparam logic [3:0] SEL_CTRL = 4'h6;
  localparam logic [3:0] SEL_EFF0 = 4'h7;
  localparam logic [3:0] SEL_EFF1 = 4'h8;
  localparam logic [3:0] SEL_STAT = 4'h9;
  localparam logic [3:0] SEL_NONE = 4'hf;

  // Group 0 field positions
  localparam int PWM_BIT = 20;
  localparam int CONVERTER_BIT = 16;
  localparam int RATE_LSB = 8;
  localparam int WATCHDOG_BIT = 3;
  localparam int TRACE_BIT = 2;
  localparam int DEBUG_BIT = 1;
  localparam int JTAG_BIT = 0;
  // Group 1 field positions, then the auto-gating bit of the control register
  localparam int COMPARATOR_BIT = 24;
  localparam int TIMER2_BIT = 18;
  localparam int TIMER1_BIT = 17;
  localparam int TIMER0_BIT = 16;
  localparam int I2C_BIT = 12;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int SECOND_UART_BIT = 1;
  localparam int FIRST_UART_BIT = 0;
  localparam int AUTO_GATING_BIT = 0;

  // Writable bits, unit bits and reset values
  localparam logic [31:0] GROUP0_WMASK = 32'h0011_0f0f;
  localparam logic [31:0] GROUP1_WMASK = 32'h0107_1013;
  localparam logic [31:0] GROUP0_UNITS = 32'h0011_000f;
  localparam logic [31:0] GROUP1_UNITS = 32'h0107_1013;
  localparam logic [31:0] GROUP0_RESET = 32'h0001_0201;
  localparam logic [31:0] GROUP1_RESET = 32'h0000_0000;
  localparam logic RESET_AUTO_GATING = 1'b0;

  // Converter rate codes
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;
  localparam logic [3:0] RATE_500K = 4'h2;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP = 3'b100
  } mode_t;

endpackage

// ===== peripheral_clock_gating_banks.sv
// Run, sleep and deep-sleep clock gating banks for two peripheral groups,
// with an AXI4-Lite slave and a fault check for peripheral accesses.
// Assumes sleep requests and peripheral access probes are on clk_sys.
//
// Contract
// - Set bit clocks unit, clear bit stops it
// - Access to unclocked unit gives bus fault
// - Gating bits reset to zero unless noted
// - Three copies; sleep copies need automatic gating
// - Group 0 copies at 0x100, 0x110, 0x120
// - Group 1 copies at 0x104, 0x114, 0x124
// - Group 0 bit 20 gates PWM generator
// - Group 0 bit 16 gates converter, resets one
// - Group 0 bits 11:8 hold rate limit
// - Converter never runs above 500K samples
// - Bits 3,2,1 gate watchdog, trace, debug
// - Group 0 bit 0 gates JTAG, resets one
// - Group 1 bit 24 gates comparator zero
// - Group 1 bits 18:16 gate timers
// - Group 1 bits 12, 4 gate I2C, serial
// - Group 1 bits 1, 0 gate UARTs
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns

module peripheral_clock_gating_banks (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sleep_req, // Processor is in sleep
  input wire logic deepsleep_req, // Processor is in deep-sleep
  input wire logic access_valid, // Peripheral access probe
  input wire logic access_group, // Group of the accessed unit
  input wire logic [4:0] access_bit, // Gating bit of the accessed unit
  output logic access_fault, // Access hit an unclocked unit
  output logic access_ok, // Access hit a clocked unit
  output logic pwm_clk_en, // PWM generator clock enable
  output logic converter_clk_en, // Converter clock enable
  output logic [3:0] converter_rate_limit, // Effective rate code
  output logic watchdog_unit_gate, // Watchdog clock enable
  output logic serial_wire_trace_output, // Trace output clock enable
  output logic debug_clk_en, // Serial-wire debug clock enable
  output logic jtag_clk_en, // JTAG clock enable
  output logic analog_comparator_zero, // Comparator 0 clock enable
  output logic general_timer_zero, // Timer 0 clock enable
  output logic general_timer_one, // Timer 1 clock enable
  output logic general_timer_two, // Timer 2 clock enable
  output logic i2c_clk_en, // I2C clock enable
  output logic synchronous_serial_unit, // Synchronous serial clock enable
  output logic first_uart_unit, // First UART clock enable
  output logic second_uart_unit // Second UART clock enable
);
  import clock_gating_pkg::*;

  typedef struct packed {
    logic [2:0][1:0][31:0] gate;
    logic auto_gate;
    mode_t mode;
    logic [1:0][31:0] en;
    logic [3:0] rate;
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fault;
    logic ok;
    logic [7:0] fault_cnt;
  } state_t;

  state_t st;
  state_t next_st;

  // Map a byte address onto a register selector
  // gating, control, effective and status offsets
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    case (a)
      OFF_RUN_GATING_GROUP0: reg_sel = 4'h0;
      OFF_RUN_GATING_GROUP1: reg_sel = 4'h1;
      OFF_SLEEP_GATING_GROUP0: reg_sel = 4'h2;
      OFF_SLEEP_GATING_GROUP1: reg_sel = 4'h3;
      OFF_DEEPSLEEP_GATING_GROUP0: reg_sel = 4'h4;
      OFF_DEEPSLEEP_GATING_GROUP1: reg_sel = 4'h5;
      OFF_MAIN_CLOCK_CONFIGURATION: reg_sel = SEL_CTRL;
      OFF_EFFECTIVE_GROUP0: reg_sel = SEL_EFF0;
      OFF_EFFECTIVE_GROUP1: reg_sel = SEL_EFF1;
      OFF_GATING_STATUS: reg_sel = SEL_STAT;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~(lanes & wmask)) | (data & lanes & wmask);
  endfunction

  // Codes above the top rate fold back onto the top rate
  // rate ceiling
  function automatic logic [3:0] clamp_rate(input logic [3:0] code);
    clamp_rate = (code > RATE_500K) ? RATE_500K : code;
  endfunction

  always_comb begin
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [31:0] v;
    logic [1:0] copy;
    logic [31:0] rd;
    wsel = reg_sel(st.aw_addr);
    rsel = reg_sel(s_axi_araddr);
    v = 32'h0000_0000;
    copy = 2'd0;
    rd = 32'h0000_0000;
    next_st = st;
    next_st.fault = 1'b0;
    next_st.ok = 1'b0;

    // Address and data are captured independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Commit once both halves are held and no response is pending
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (wsel < SEL_CTRL) begin
        if (wsel[0]) begin
          v = merge(st.gate[wsel[2:1]][1], st.w_data, st.w_strb, GROUP1_WMASK);
        end else begin
          v = merge(st.gate[wsel[2:1]][0], st.w_data, st.w_strb, GROUP0_WMASK);
          v[RATE_LSB +: 4] = clamp_rate(v[RATE_LSB +: 4]);
        end
        next_st.gate[wsel[2:1]][wsel[0]] = v;
      end else if (wsel == SEL_CTRL) begin
        if (st.w_strb[0]) begin
          next_st.auto_gate = st.w_data[AUTO_GATING_BIT];
        end
      end else if (wsel == SEL_NONE) begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready = !next_st.w_full && !next_st.bvalid;

    // Read path answers one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      case (rsel)
        4'h0: rd = st.gate[0][0];
        4'h1: rd = st.gate[0][1];
        4'h2: rd = st.gate[1][0];
        4'h3: rd = st.gate[1][1];
        4'h4: rd = st.gate[2][0];
        4'h5: rd = st.gate[2][1];
        SEL_CTRL: rd = {31'h0000_0000, st.auto_gate};
        SEL_EFF0: rd = st.en[0] | {20'h0_0000, st.rate, 8'h00};
        SEL_EFF1: rd = st.en[1];
        SEL_STAT: rd = {16'h0000, st.fault_cnt, 5'h00, st.mode};
        default: rd = 32'h0000_0000;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    next_st.arready = !next_st.rvalid;

    // Deep-sleep outranks sleep when both are requested
    if (deepsleep_req) begin
      next_st.mode = MODE_DEEP;
    end else if (sleep_req) begin
      next_st.mode = MODE_SLEEP;
    end else begin
      next_st.mode = MODE_RUN;
    end

    // Copy selection
    case (st.mode)
      MODE_RUN: copy = 2'd0;
      MODE_SLEEP: copy = st.auto_gate ? 2'd1 : 2'd0;
      MODE_DEEP: copy = st.auto_gate ? 2'd2 : 2'd0;
      default: copy = 2'd0;
    endcase

    // Enables are whole-register updates from flops, so downstream clock
    // gates see one clean change per mode switch and no combinational hazard
    // glitch-free switch
    next_st.en[0] = st.gate[copy][0] & GROUP0_UNITS;
    next_st.en[1] = st.gate[copy][1] & GROUP1_UNITS;
    next_st.rate = clamp_rate(st.gate[copy][0][RATE_LSB +: 4]);

    if (access_valid) begin
      if (st.en[access_group][access_bit]) begin
        next_st.ok = 1'b1;
      end else begin
        next_st.fault = 1'b1;
        // Saturating so the count never wraps to look clean
        if (st.fault_cnt != 8'hff) begin
          next_st.fault_cnt = st.fault_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st.gate <= {GROUP1_RESET, GROUP0_RESET, GROUP1_RESET, GROUP0_RESET,
                  GROUP1_RESET, GROUP0_RESET};
      st.auto_gate <= RESET_AUTO_GATING;
      st.mode <= MODE_RUN;
      st.en <= {GROUP1_RESET & GROUP1_UNITS, GROUP0_RESET & GROUP0_UNITS};
      st.rate <= GROUP0_RESET[RATE_LSB +: 4];
      st.aw_full <= 1'b0;
      st.aw_addr <= 12'h000;
      st.w_full <= 1'b0;
      st.w_data <= 32'h0000_0000;
      st.w_strb <= 4'h0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.bvalid <= 1'b0;
      st.bresp <= RESP_OKAY;
      st.arready <= 1'b1;
      st.rvalid <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.rresp <= RESP_OKAY;
      st.fault <= 1'b0;
      st.ok <= 1'b0;
      st.fault_cnt <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign access_fault = st.fault;
  assign access_ok = st.ok;
  assign converter_rate_limit = st.rate;

  assign pwm_clk_en = st.en[0][PWM_BIT];
  assign converter_clk_en = st.en[0][CONVERTER_BIT];
  assign watchdog_unit_gate = st.en[0][WATCHDOG_BIT];
  assign serial_wire_trace_output = st.en[0][TRACE_BIT];
  assign debug_clk_en = st.en[0][DEBUG_BIT];
  assign jtag_clk_en = st.en[0][JTAG_BIT];
  assign analog_comparator_zero = st.en[1][COMPARATOR_BIT];
  assign general_timer_zero = st.en[1][TIMER0_BIT];
  assign general_timer_one = st.en[1][TIMER1_BIT];
  assign general_timer_two = st.en[1][TIMER2_BIT];
  assign i2c_clk_en = st.en[1][I2C_BIT];
  assign synchronous_serial_unit = st.en[1][SYNC_SERIAL_BIT];
  assign first_uart_unit = st.en[1][FIRST_UART_BIT];
  assign second_uart_unit = st.en[1][SECOND_UART_BIT];

endmodule

// ===== clock_gating_props.sv
// Checker for the clock gating banks: bus answers, probes and enables.
// Bound to the top module, sees its ports only.
`timescale 1ns/1ns

module clock_gating_props
  import clock_gating_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic [11:0] s_axi_awaddr, // AW addr
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic [31:0] s_axi_wdata, // W data
  input wire logic [3:0] s_axi_wstrb, // W strobes
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [11:0] s_axi_araddr, // AR addr
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  input wire logic sleep_req, // Sleep
  input wire logic deepsleep_req, // Deep-sleep
  input wire logic access_valid, // Probe
  input wire logic access_group, // Probe group
  input wire logic [4:0] access_bit, // Probe bit
  input wire logic access_fault, // Fault
  input wire logic access_ok, // Ok
  input wire logic pwm_clk_en, // PWM enable
  input wire logic converter_clk_en, // Converter enable
  input wire logic jtag_clk_en, // JTAG enable
  input wire logic [3:0] converter_rate_limit // Rate code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic quiet;
  logic wtake;
  assign quiet = !sleep_req && !deepsleep_req;
  assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Run copy write that clears the JTAG gate while awake
  sequence jtag_clear_s;
    wtake && quiet && s_axi_awaddr == OFF_RUN_GATING_GROUP0 && s_axi_wstrb[0] &&
      !s_axi_wdata[JTAG_BIT];
  endsequence

  a_reset_state: assert property (
    $rose(rst_n) |-> jtag_clk_en && converter_clk_en && !pwm_clk_en &&
    converter_rate_limit == RATE_500K) else $error("Enables wrong after reset");
  a_probe_fault: assert property (
    access_valid && !access_group && access_bit == 5'd0 && !jtag_clk_en
    |=> access_fault && !access_ok) else $error("No fault for unclocked unit");
  a_probe_ok: assert property (
    access_valid && !access_group && access_bit == 5'd0 && jtag_clk_en
    |=> access_ok && !access_fault) else $error("Clocked unit refused");
  a_reserved_fault: assert property (
    access_valid && !access_group && access_bit == 5'd5 |=> access_fault)
    else $error("Non-unit bit did not fault");
  a_probe_quiet: assert property (
    !access_valid |=> !access_fault && !access_ok) else $error("Probe answer without probe");
  a_rate_capped: assert property (
    converter_rate_limit <= RATE_500K) else $error("Converter rate above maximum");
  a_jtag_clear: assert property (
    jtag_clear_s ##1 quiet [*2] |=> !jtag_clk_en) else $error("JTAG still clocked");
  a_group0_okay: assert property (
    wtake && s_axi_awaddr == OFF_RUN_GATING_GROUP0 |=> ##1 s_axi_bvalid &&
    s_axi_bresp == RESP_OKAY) else $error("Group 0 write not answered okay");
  a_group1_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RUN_GATING_GROUP1
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY) else $error("Group 1 read not okay");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
endmodule

bind peripheral_clock_gating_banks clock_gating_props chk (.*);

// ===== peripheral_clock_gating_banks_tb.sv
// Testbench for the clock gating banks: registers, enables, probes, modes.
// Drives every port itself; the checker is bound from its own file.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module peripheral_clock_gating_banks_tb;
  import clock_gating_pkg::*;
  logic clk_sys = 0, rst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, converter_rate_limit;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] access_bit = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, sleep_req = 0, deepsleep_req = 0, access_valid = 0, access_group = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic access_fault, access_ok, pwm_clk_en, converter_clk_en, watchdog_unit_gate;
  logic serial_wire_trace_output, debug_clk_en, jtag_clk_en, analog_comparator_zero;
  logic general_timer_zero, general_timer_one, general_timer_two, i2c_clk_en;
  logic synchronous_serial_unit, first_uart_unit, second_uart_unit;
  logic [5:0] g0_en;
  logic [7:0] g1_en;
  int mismatches = 0, tests_run = 0, cycles = 0;

  peripheral_clock_gating_banks uut (.*);
  assign g0_en = {pwm_clk_en, converter_clk_en, watchdog_unit_gate, serial_wire_trace_output,
    debug_clk_en, jtag_clk_en};
  assign g1_en = {analog_comparator_zero, general_timer_two, general_timer_one,
    general_timer_zero, i2c_clk_en, synchronous_serial_unit, second_uart_unit, first_uart_unit};

  // A late write leaves bready low until the response is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit late = 1'b0);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    if (late) begin
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Enables trail a write commit by one edge and a mode request by two edges
  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic probe(input logic g, input logic [4:0] b, input logic ok);
    @(posedge clk_sys);
    access_valid <= 1'b1;
    access_group <= g;
    access_bit <= b;
    @(posedge clk_sys);
    access_valid <= 1'b0;
    @(posedge clk_sys);
    `CHK("access_ok", ok, access_ok)
    `CHK("access_fault", !ok, access_fault)
  endtask

  task automatic t_reset;
    logic [11:0] offs [6] = '{12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124};
    for (int i = 0; i < 6; i++) begin
      rdr(offs[i]);
      `CHK("reset value", (i % 2) ? 32'h0 : 32'h0001_0201, rd)
      `CHK("read resp", RESP_OKAY, resp)
    end
    `CHK("group0 enables", 6'b010001, g0_en)
    `CHK("group1 enables", 8'h00, g1_en)
    `CHK("rate limit", RATE_500K, converter_rate_limit)
    probe(1'b0, 5'd0, 1'b1);
    probe(1'b0, 5'd5, 1'b0);
  endtask

  task automatic t_group0;
    wr(12'h100, 32'h0011_0f0f);
    rdr(12'h100);
    `CHK("group0 all", 32'h0011_020f, rd)
    settle;
    `CHK("group0 on", 6'h3f, g0_en)
    `CHK("rate clamp", RATE_500K, converter_rate_limit)
    wr(12'h100, 32'h0);
    `CHK("write resp", RESP_OKAY, resp)
    settle;
    `CHK("group0 off", 6'h00, g0_en)
    probe(1'b0, 5'd0, 1'b0);
    for (int c = 0; c < 3; c++) begin
      wr(12'h100, 32'(c) << 8);
      settle;
      `CHK("rate code", 4'(c), converter_rate_limit)
    end
  endtask

  task automatic t_group1;
    wr(12'h104, 32'h0107_1013);
    rdr(12'h104);
    `CHK("group1 all", 32'h0107_1013, rd)
    settle;
    `CHK("group1 on", 8'hff, g1_en)
    probe(1'b1, 5'd12, 1'b1);
    wr(12'h104, 32'h0000_0002);
    settle;
    `CHK("group1 uart", 8'h02, g1_en)
    probe(1'b1, 5'd0, 1'b0);
    rdr(12'h200);
    `CHK("unmapped read", RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h0, rd)
    wr(12'h204, 32'hffff_ffff, 1'b1);
    `CHK("unmapped write", RESP_SLVERR, resp)
  endtask

  task automatic t_modes;
    wr(12'h100, 32'h0000_0001);
    wr(12'h110, 32'h0000_0008);
    wr(12'h120, 32'h0000_0004);
    wr(12'h130, 32'h0000_0001);
    settle;
    `CHK("run copy", 6'h01, g0_en)
    sleep_req <= 1'b1;
    settle;
    `CHK("sleep copy", 6'h08, g0_en)
    `CHK("sleep group1", 8'h00, g1_en)
    rdr(12'h134);
    `CHK("effective group0", 32'h0000_0008, rd)
    deepsleep_req <= 1'b1;
    settle;
    `CHK("deep copy", 6'h04, g0_en)
    rdr(12'h13c);
    `CHK("mode status", 32'h0000_0304, rd)
    wr(12'h130, 32'h0);
    settle;
    `CHK("gating off", 6'h01, g0_en)
    sleep_req <= 1'b0;
    deepsleep_req <= 1'b0;
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // A hung handshake would stall the run forever
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up;
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_group0;
    t_group1;
    t_modes;
    wrap_up;
  end
endmodule
